/* bench/ccmr_host.sv */
// partner: host register access with the blackout after soft reset
`timescale 1ns/10ps
`default_nettype none
module ccmr_host import ccmr_pkg::*; #(
  parameter int unsigned BLACKOUT = 30  // idle cycles after soft reset
) (
  input  wire logic       i_core_clk,  // clock
  input  wire logic       i_rd_valid,  // read answer
  input  wire logic [7:0] i_rdata,     // read data
  output logic            o_wr_en,     // write strobe
  output logic            o_rd_en,     // read strobe
  output logic      [7:0] o_addr,      // address
  output logic      [7:0] o_wdata      // write data
);
  initial begin
    {o_wr_en, o_rd_en, o_addr, o_wdata} = 18'h0_0000;
  end
  // strobes drop to 0; released address and data lines show the inverse of the last value
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    q = 'x;
    @(posedge i_core_clk);
    #1;
    {o_wr_en, o_rd_en, o_addr, o_wdata} = {w, !w, a, d};
    @(posedge i_core_clk);
    #1;
    {o_wr_en, o_rd_en, o_addr, o_wdata} = {2'b00, ~a, ~d};
    for (int n = 0; n < 6 && !w && i_rd_valid !== 1'b1; n++)
      @(posedge i_core_clk);
    if (!w && i_rd_valid === 1'b1)
      q = i_rdata;
    if (w && a == ADDR_RST_CAL && d[7])
      repeat (BLACKOUT) @(posedge i_core_clk);
  endtask
endmodule // ccmr_host
`default_nettype wire

/* bench/ccmr_regs_props.sv */
// checker: port relations of the control register bank
`timescale 1ns/10ps
`default_nettype none
module ccmr_regs_props import ccmr_pkg::*; #(
  parameter int unsigned SOFT_RST_CYC = SOFT_RST_HOLD_CYC,  // soft reset hold
  parameter int unsigned CAL_CYC      = CAL_TIME_CYC,       // calibration
  parameter int unsigned LOCK_CYC     = LOCK_TIME_CYC       // lock time
) (
  input wire logic       i_core_clk,             // clock
  input wire logic       i_sys_rst,              // reset
  input wire logic       i_wr_en,                // write
  input wire logic       i_rd_en,                // read
  input wire logic [7:0] i_addr,                 // address
  input wire logic [7:0] i_wdata,                // data
  input wire logic [7:0] o_rdata,                // read data
  input wire logic       o_in_reset,             // in reset
  input wire logic       o_clk_out_en,           // outputs on
  input wire logic       o_lock_loss_alarm,      // alarm
  input wire logic       o_quick_acquire_enable, // fast acquire
  input wire logic [1:0] o_slow_input_signal_loss_select,          // slow detector
  input wire logic [1:0] o_full_input_signal_loss_select,          // full detector
  input wire logic [5:0] o_rate_active           // settings
);
  wire logic acc = !o_in_reset && i_wr_en && i_addr == ADDR_RST_CAL;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_busy; o_lock_loss_alarm [*6]; endsequence
  sequence s_on; ##[0:3] o_clk_out_en; endsequence
  property p_soft; acc && i_wdata[7] |-> ##[1:3] o_in_reset; endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");
  property p_off; o_in_reset |-> o_lock_loss_alarm && !o_clk_out_en && !o_quick_acquire_enable; endproperty
  a_off: assert property (p_off) else $error("outputs live in reset");
  property p_cal; acc && i_wdata[6] && !i_wdata[7] |-> ##2 s_busy; endproperty
  a_cal: assert property (p_cal) else $error("alarm low in calibration");
  property p_done; $fell(o_lock_loss_alarm) && !o_in_reset |-> s_on; endproperty
  a_done: assert property (p_done) else $error("no lock after alarm fell");
  property p_lock; o_clk_out_en |-> !o_lock_loss_alarm; endproperty
  a_lock: assert property (p_lock) else $error("outputs on while unlocked");
  property p_dec; (o_slow_input_signal_loss_select & o_full_input_signal_loss_select) == 2'h0; endproperty
  a_dec: assert property (p_dec) else $error("two detectors at once");
  property p_qa; o_quick_acquire_enable |-> o_lock_loss_alarm; endproperty
  a_qa: assert property (p_qa) else $error("fast acquire while locked");
  property p_rate; !o_in_reset && $changed(o_rate_active) |-> o_lock_loss_alarm; endproperty
  a_rate: assert property (p_rate) else $error("settings changed outside calibration");
  property p_rd0; i_rd_en && !o_in_reset && !(i_addr inside {[8'h89:8'h8b]}) |-> ##2 o_rdata == RD_ZERO; endproperty
  a_rd0: assert property (p_rd0) else $error("start bit not cleared");
endmodule // ccmr_regs_props
bind ccmr_regs ccmr_regs_props #(.SOFT_RST_CYC(SOFT_RST_CYC), .CAL_CYC(CAL_CYC), .LOCK_CYC(LOCK_CYC)) i_props (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_in_reset(o_in_reset),
  .o_clk_out_en(o_clk_out_en), .o_lock_loss_alarm(o_lock_loss_alarm),
  .o_quick_acquire_enable(o_quick_acquire_enable), .o_slow_input_signal_loss_select(o_slow_input_signal_loss_select),
  .o_full_input_signal_loss_select(o_full_input_signal_loss_select), .o_rate_active(o_rate_active));
`default_nettype wire

/* bench/tb_ccmr_regs.sv */
// testbench: reset values, monitor selects, calibration and soft reset
`timescale 1ns/10ps
`default_nettype none
module tb_ccmr_regs;
  import ccmr_pkg::*;
  logic       clk, rst, wen, rd, rdv, inr, cke, lla, qae;
  logic [7:0] addr, wdata, rdata, v;
  logic [5:0] cfg, rate;
  logic [1:0] slw, ful, ofs, c;
  int         num_errors, checked, n0, n1;
  ccmr_regs #(.SOFT_RST_CYC(20), .CAL_CYC(8), .LOCK_CYC(32)) i_ccmr_regs (
    .i_core_clk(clk), .i_sys_rst(rst), .i_wr_en(wen), .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata),
    .i_rate_cfg(cfg), .o_rdata(rdata), .o_rd_valid(rdv), .o_in_reset(inr), .o_clk_out_en(cke),
    .o_lock_loss_alarm(lla), .o_quick_acquire_enable(qae), .o_slow_input_signal_loss_select(slw),
    .o_full_input_signal_loss_select(ful), .o_offset_mon_en(ofs), .o_rate_active(rate));
  ccmr_host #(.BLACKOUT(30)) i_ccmr_host (.i_core_clk(clk), .i_rd_valid(rdv), .i_rdata(rdata),
    .o_wr_en(wen), .o_rd_en(rd), .o_addr(addr), .o_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_ccmr_host.xfer(1'b1, a, d, v);
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    i_ccmr_host.xfer(1'b0, a, 8'h00, v);
    chk(nm, v & m, exp);
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task t_defaults;
    chk("sel", {2'h0, ful, slw, ofs}, 8'h33);
    chk("qa", {qae, lla}, 8'h01);
    rc("r89", ADDR_QUICK_ACQ, 8'h00, 8'hff);
    rc("r8a", ADDR_LOS_UPPER, 8'h0f, 8'hff);
    rc("r8b", ADDR_LOS_LOWER, 8'h33, 8'h33);
  endtask
  task t_los;
    for (int i = 0; i < 5; i++) begin
      c = 2'(i);
      wr(ADDR_LOS_UPPER, (i == 4) ? 8'h03 : {6'h00, c[1], c[1]});
      wr(ADDR_LOS_LOWER, (i == 4) ? 8'h20 : {2'h0, c[0], c[0], 2'h0, c});
      repeat (3) @(posedge clk);
      chk("slow", 8'(slw), (i == 4) ? 8'h01 : (c == 2'h2) ? 8'h03 : 8'h00);
      chk("full", 8'(ful), (i == 4) ? 8'h02 : (c == 2'h3) ? 8'h03 : 8'h00);
      chk("ofs", 8'(ofs), 8'(c));
    end
  endtask
  task t_cal(input logic [7:0] q, output int n);
    logic s;
    s = 1'b0;
    wr(ADDR_QUICK_ACQ, q | 8'hfe);
    rc("r89", ADDR_QUICK_ACQ, q, 8'hff);
    wr(ADDR_RST_CAL, 8'h40);
    for (n = 0; n < 300 && (n < 3 || lla !== 1'b0); n++) begin
      @(posedge clk);
      s = s | qae;
    end
    chk("qa", 8'(s), q);
    chk("rate", 8'(rate), 8'(cfg));
    #1 cfg = ~cfg;
    repeat (4) @(posedge clk);
    chk("lock", {rate, cke, lla}, {~cfg, 2'b10});
    rc("r88", ADDR_RST_CAL, 8'h00, 8'hff);
  endtask
  task t_soft;
    wr(ADDR_LOS_UPPER, 8'h00);
    fork
      wr(ADDR_RST_CAL, 8'h80);
    join_none
    repeat (5) @(posedge clk);
    chk("inrst", {inr, cke}, 8'h02);
    wait fork;
    chk("inrst", 8'(inr), 8'h00);
    rc("r89", ADDR_QUICK_ACQ, 8'h00, 8'hff);
    wr(8'h8c, 8'hff);
    rc("r8c", 8'h8c, 8'h00, 8'hff);
    rc("r8a", ADDR_LOS_UPPER, 8'h0f, 8'hff);
    rc("r8b", ADDR_LOS_LOWER, 8'h33, 8'h33);
    chk("sel", {2'h0, ful, slw, ofs}, 8'h33);
    chk("alarm", {qae, lla}, 8'h01);
  endtask
  initial begin
    {rst, cfg, num_errors, checked} = {1'b1, 6'h2d, 64'h0};
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    t_defaults;
    t_los;
    t_cal(8'h00, n0);
    t_cal(8'h01, n1);
    chk("fast", 8'(n1 < n0), 8'h01);
    t_soft;
    finish_test;
  end
  initial begin
    #50us;
    num_errors++;
    finish_test;
  end
endmodule // tb_ccmr_regs
`default_nettype wire

/* rtl/ccmr_los_decode.sv */
// signal-loss select decoder for one input
`timescale 1ns/10ps
`default_nettype none
module ccmr_los_decode (
  ccmr_mon_if.dec mon   // select in, enables out
);
  import ccmr_pkg::*;
  ccmr_mon_type mode;
  always_comb begin
    unique case (mon.los_sel)
      LOS_SEL_FULL: mode = CCMR_MON_FULL;  // RQ10
      LOS_SEL_SLOW: mode = CCMR_MON_SLOW;  // RQ10
      default:      mode = CCMR_MON_OFF;   // reserved code treated as off RQ10
    endcase
    mon.slow_en = (mode == CCMR_MON_SLOW);
    mon.full_en = (mode == CCMR_MON_FULL);
  end
endmodule // ccmr_los_decode
`default_nettype wire

/* rtl/ccmr_mon_if.sv */
// interface: per-input monitor selection handed from the register bank to the decoder
`timescale 1ns/10ps
`default_nettype none
interface ccmr_mon_if;
  logic [1:0] los_sel;   // two-bit signal-loss select
  logic       slow_en;   // slow detector enabled
  logic       full_en;   // full detector enabled
  modport regs (output los_sel, input slow_en, input full_en);
  modport dec  (input los_sel, output slow_en, output full_en);
endinterface
`default_nettype wire

/* rtl/ccmr_pkg.sv */
// package: register map, field positions, reset values and timing for the control and monitor registers
package ccmr_pkg;
  localparam int unsigned CLK_FREQ_HZ        = 40_000_000;
  localparam int unsigned SOFT_RST_HOLD_US   = 10_000;          // 10 ms blackout after soft reset
  localparam int unsigned SOFT_RST_HOLD_CYC  = (CLK_FREQ_HZ / 1_000_000) * SOFT_RST_HOLD_US;
  localparam int unsigned CAL_TIME_CYC       = 64;              // default self-calibration length
  localparam int unsigned LOCK_TIME_CYC      = 1024;            // default acquisition length
  localparam int unsigned FAST_LOCK_DIV      = 4;               // quick acquire shortens lock by this
  localparam int unsigned RST_CNT_W          = 20;

  localparam logic [7:0] ADDR_RST_CAL   = 8'h88;
  localparam logic [7:0] ADDR_QUICK_ACQ = 8'h89;
  localparam logic [7:0] ADDR_LOS_UPPER = 8'h8a;
  localparam logic [7:0] ADDR_LOS_LOWER = 8'h8b;

  localparam int unsigned BIT_SOFT_RST  = 7;
  localparam int unsigned BIT_CAL_START = 6;
  localparam int unsigned BIT_QUICK_ACQ = 0;
  localparam int unsigned BIT_LOS_UP_0  = 0;  // input one upper select bit; input two at +1
  localparam int unsigned BIT_LOS_LO_0  = 4;  // input one lower select bit; input two at +1
  localparam int unsigned BIT_OFS_EN_0  = 0;  // input one offset enable; input two at +1

  localparam logic [7:0] RST_QUICK_ACQ = 8'h00;
  localparam logic [7:0] RST_LOS_UPPER = 8'h0f;
  localparam logic [7:0] RST_LOS_LOWER = 8'hff;
  localparam logic [7:0] RD_ZERO       = 8'h00;
  localparam logic [7:0] MASK_QUICK_ACQ = 8'h01;
  localparam logic [7:0] MASK_LOS_UPPER = 8'h03;
  localparam logic [7:0] MASK_LOS_LOWER = 8'h33;

  localparam logic [1:0] LOS_SEL_OFF  = 2'h0;
  localparam logic [1:0] LOS_SEL_RSVD = 2'h1;
  localparam logic [1:0] LOS_SEL_SLOW = 2'h2;
  localparam logic [1:0] LOS_SEL_FULL = 2'h3;

  localparam int unsigned NUM_INPUTS = 2;

  typedef enum logic [1:0] {
    CCMR_MON_OFF,
    CCMR_MON_SLOW,
    CCMR_MON_FULL
  } ccmr_mon_type;
endpackage

/* rtl/ccmr_regs.sv */
// control and monitor-enable register bank with soft reset and self-calibration sequencing
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RQ1 - Writing 1 to bit 7 of the reset register resets all internal logic like the reset pin, with outputs disabled.
// RQ2 - After a soft reset the host must leave the port alone for at least 10 ms.
// RQ3 - Writing 1 to bit 6 of the reset register starts self-calibration and the bit clears itself.
// RQ4 - Completion of self-calibration is shown by the lock-loss alarm going low.
// RQ5 - The host must supply a stable input clock within 100 ppm before starting calibration.
// RQ6 - Divider, rate range and bandwidth settings only take effect after a new calibration.
// RQ7 - With quick acquire enabled the loop locks faster by varying its bandwidth during acquisition.
// RQ8 - The quick-acquire register resets to zero so quick acquisition is off by default.
// RQ9 - Each input's signal-loss select has its upper bit in the first select register and lower bit in the second.
// RQ10 - Select 00 turns monitoring off, 10 picks the slow detector, 11 the full detector, 01 is reserved.
// RQ11 - Each input has its own offset-monitor enable, input two at bit 1 and input one at bit 0.
// RQ12 - The first select register resets to 0000 1111.
// RQ13 - The second select register resets to all ones.
// RQ14 - Lock-loss status reads 0 while locked and 1 while unlocked.
// RQ15 - The lock-loss alarm stays high from calibration start until calibration ends.
module ccmr_regs #(
  parameter int unsigned SOFT_RST_CYC = ccmr_pkg::SOFT_RST_HOLD_CYC,  // soft reset hold
  parameter int unsigned CAL_CYC      = ccmr_pkg::CAL_TIME_CYC,       // calibration length
  parameter int unsigned LOCK_CYC     = ccmr_pkg::LOCK_TIME_CYC       // normal lock time
) (
  input  wire logic       i_core_clk,          // core clock, 40 MHz
  input  wire logic       i_sys_rst,           // pin reset, sync active high
  input  wire logic       i_wr_en,             // register write strobe
  input  wire logic       i_rd_en,             // register read strobe
  input  wire logic [7:0] i_addr,              // register address
  input  wire logic [7:0] i_wdata,             // write data
  input  wire logic [5:0] i_rate_cfg,          // divider/rate/bandwidth settings to latch
  output logic      [7:0] o_rdata,             // read data
  output logic            o_rd_valid,          // read data valid pulse
  output logic            o_in_reset,          // internal reset active, outputs disabled
  output logic            o_clk_out_en,        // clock outputs enabled
  output logic            o_lock_loss_alarm,   // lock-loss alarm
  output logic            o_quick_acquire_enable, // quick acquire active
  output logic      [1:0] o_slow_input_signal_loss_select,       // slow detector enable per input
  output logic      [1:0] o_full_input_signal_loss_select,       // full detector enable per input
  output logic      [1:0] o_offset_mon_en,     // frequency-offset monitor enable per input
  output logic      [5:0] o_rate_active        // settings in use since last calibration
);
  import ccmr_pkg::*;

  typedef enum logic [1:0] {CCMR_IDLE, CCMR_CAL, CCMR_ACQ, CCMR_LOCKED} ccmr_state_type;

  ccmr_state_type  st_r, st_nxt;
  logic [RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt, cnt_r, cnt_nxt;
  logic [7:0] qa_r, qa_nxt, up_r, up_nxt, lo_r, lo_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rdv_r, rdv_nxt, rst_r, rst_nxt, lol_r, lol_nxt;
  logic [1:0] slow_r, full_r, ofs_r;
  logic [5:0] rate_r, rate_nxt;
  logic [1:0] slow_w, full_w;
  logic       int_rst, soft_hit, cal_hit, out_off;

  ccmr_mon_if mon [NUM_INPUTS] ();

  genvar g;
  generate
    // each input's select takes one bit from each select register
    for (g = 0; g < NUM_INPUTS; g++) begin : g_in
      assign mon[g].los_sel = {up_r[BIT_LOS_UP_0+g], lo_r[BIT_LOS_LO_0+g]};  // RQ9
      ccmr_los_decode u_dec (
        .mon (mon[g])
      );
      assign slow_w[g] = mon[g].slow_en;
      assign full_w[g] = mon[g].full_en;
    end
  endgenerate

  assign soft_hit = i_wr_en && !rst_r && (i_addr == ADDR_RST_CAL) && i_wdata[BIT_SOFT_RST];
  assign int_rst  = i_sys_rst || rst_r;  // RQ1
  // outputs go quiet in the cycle the soft reset is written, before the state registers clear
  assign out_off  = int_rst || soft_hit;  // RQ1
  // a write with both bits set is taken as a soft reset only
  assign cal_hit  = i_wr_en && !rst_r && (i_addr == ADDR_RST_CAL) && i_wdata[BIT_CAL_START]
                    && !i_wdata[BIT_SOFT_RST];  // RQ3

  // soft reset hold: the port is blind for the whole blackout
  always_comb begin
    rst_nxt     = rst_r;
    rst_cnt_nxt = rst_cnt_r;
    if (soft_hit) begin
      rst_nxt     = 1'b1;  // RQ1
      rst_cnt_nxt = RST_CNT_W'(SOFT_RST_CYC - 1);  // RQ2
    end else if (rst_r) begin
      if (rst_cnt_r == '0) begin
        rst_nxt = 1'b0;
      end else begin
        rst_cnt_nxt = rst_cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rst_r     <= 1'b0;
      rst_cnt_r <= '0;
    end else begin
      rst_r     <= rst_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // registers, read port, calibration sequencer
  always_comb begin
    qa_nxt    = qa_r;
    up_nxt    = up_r;
    lo_nxt    = lo_r;
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    rate_nxt  = rate_r;
    lol_nxt   = lol_r;
    rdv_nxt   = i_rd_en && !rst_r;
    rdata_nxt = RD_ZERO;
    if (i_wr_en && !rst_r) begin
      unique case (i_addr)
        ADDR_QUICK_ACQ: qa_nxt = i_wdata & MASK_QUICK_ACQ;
        ADDR_LOS_UPPER: up_nxt = (up_r & ~MASK_LOS_UPPER) | (i_wdata & MASK_LOS_UPPER);  // RQ9
        ADDR_LOS_LOWER: lo_nxt = (lo_r & ~MASK_LOS_LOWER) | (i_wdata & MASK_LOS_LOWER);  // RQ9 RQ11
        default: ;
      endcase
    end
    // reads during the blackout are dropped and give no valid pulse
    if (i_rd_en && !rst_r) begin
      unique case (i_addr)
        ADDR_RST_CAL:   rdata_nxt = RD_ZERO;  // self-clearing bits read back low
        ADDR_QUICK_ACQ: rdata_nxt = qa_r;
        ADDR_LOS_UPPER: rdata_nxt = up_r;
        ADDR_LOS_LOWER: rdata_nxt = lo_r;
        default:        rdata_nxt = RD_ZERO;
      endcase
    end
    // alarm held high through calibration and acquisition
    unique case (st_r)
      CCMR_IDLE: lol_nxt = 1'b1;
      CCMR_CAL: begin
        lol_nxt = 1'b1;  // RQ15
        if (cnt_r == '0) begin
          st_nxt   = CCMR_ACQ;
          rate_nxt = i_rate_cfg;  // RQ6
          cnt_nxt  = qa_r[BIT_QUICK_ACQ] ? RST_CNT_W'(LOCK_CYC / FAST_LOCK_DIV)
                                         : RST_CNT_W'(LOCK_CYC);  // RQ7
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      CCMR_ACQ: begin
        lol_nxt = 1'b1;  // RQ14
        if (cnt_r == '0) begin
          st_nxt  = CCMR_LOCKED;
          lol_nxt = 1'b0;  // RQ4
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      CCMR_LOCKED: lol_nxt = 1'b0;  // RQ14
    endcase
    if (cal_hit) begin
      st_nxt  = CCMR_CAL;  // RQ3
      cnt_nxt = RST_CNT_W'(CAL_CYC - 1);
      lol_nxt = 1'b1;  // RQ15
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (int_rst) begin  // RQ1
      qa_r    <= RST_QUICK_ACQ;  // RQ8
      up_r    <= RST_LOS_UPPER;  // RQ12
      lo_r    <= RST_LOS_LOWER;  // RQ13
      st_r    <= CCMR_IDLE;
      cnt_r   <= '0;
      rate_r  <= '0;
      lol_r   <= 1'b1;
      rdv_r   <= 1'b0;
      rdata_r <= RD_ZERO;
      slow_r  <= '0;
      full_r  <= '0;
      ofs_r   <= '0;
    end else begin
      qa_r    <= qa_nxt;
      up_r    <= up_nxt;
      lo_r    <= lo_nxt;
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      rate_r  <= rate_nxt;
      lol_r   <= lol_nxt;
      rdv_r   <= rdv_nxt;
      rdata_r <= rdata_nxt;
      slow_r  <= slow_w;
      full_r  <= full_w;
      ofs_r   <= {lo_r[BIT_OFS_EN_0+1], lo_r[BIT_OFS_EN_0]};  // RQ11
    end
  end

  // output stage registered on the pin reset; soft reset shows through o_in_reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_in_reset             <= 1'b1;
      o_clk_out_en           <= 1'b0;
      o_lock_loss_alarm      <= 1'b1;
      o_quick_acquire_enable <= 1'b0;
      o_slow_input_signal_loss_select          <= '0;
      o_full_input_signal_loss_select          <= '0;
      o_offset_mon_en        <= '0;
      o_rate_active          <= '0;
      o_rdata                <= RD_ZERO;
      o_rd_valid             <= 1'b0;
    end else begin
      o_in_reset             <= out_off;                                      // RQ1
      o_clk_out_en           <= !out_off && (st_r == CCMR_LOCKED);            // RQ1
      o_lock_loss_alarm      <= lol_r || out_off;                             // RQ1 RQ4
      o_quick_acquire_enable <= !out_off && qa_r[BIT_QUICK_ACQ] && (st_r == CCMR_ACQ);  // RQ1 RQ7
      o_slow_input_signal_loss_select          <= slow_r;
      o_full_input_signal_loss_select          <= full_r;
      o_offset_mon_en        <= ofs_r;
      o_rate_active          <= rate_r;
      o_rdata                <= rdata_r;
      o_rd_valid             <= rdv_r;
    end
  end
endmodule // ccmr_regs
`default_nettype wire
